// ---- shared/lspm_pkg.sv ----
package lspm_pkg;

  typedef enum logic [1:0] {SPD_10, SPD_100, SPD_1000, SPD_RSVD} lspm_speed_t;
  typedef enum logic [1:0] {CH_A, CH_B, CH_C, CH_D} lspm_chan_t;
  typedef enum logic [1:0] {ROLE_UNUSED, ROLE_TX, ROLE_RX, ROLE_BIDIR} lspm_role_t;

  localparam int PAIRS = 4;
  localparam int PAIR_MAP_W = 8;
  // Group is pins 7,6,1,0 in that bit order; index 5 has no slot at all
  localparam int PIN_W = 4;

  localparam logic LED_ON = 1'b0;
  localparam logic LED_OFF = 1'b1;

  localparam logic [PIN_W-1:0] PIN_DIR_RST = 4'h0;
  localparam logic [PIN_W-1:0] PIN_OUT_RST = 4'h0;
  localparam logic [PIN_W-1:0] PIN_LVL_RST = 4'h0;

  // Straight map is also the reset value of the channel outputs
  localparam logic [PAIR_MAP_W-1:0] PAIR_CHAN_STR = 8'he4;
  localparam logic [PAIR_MAP_W-1:0] PAIR_CHAN_XOVER = 8'hb1;
  localparam logic [PAIR_MAP_W-1:0] ROLE_MAP_IDLE = 8'h00;
  localparam logic [PAIR_MAP_W-1:0] ROLE_MAP_GIG = 8'hff;
  localparam logic [PAIR_MAP_W-1:0] ROLE_MAP_SLOW_STR = 8'h09;
  localparam logic [PAIR_MAP_W-1:0] ROLE_MAP_SLOW_XO = 8'h06;

  localparam int CLK_MHZ = 10;
  localparam int FLASH_US = 50000;
  localparam int FLASH_CNT_W = 20;
  localparam logic [FLASH_CNT_W-1:0] FLASH_CYC = FLASH_CNT_W'(FLASH_US * CLK_MHZ);

  // Crossover swaps A/B and C/D, which is the low bit of the channel code
  function automatic lspm_chan_t pair_chan(input logic xover, input logic [1:0] idx);
    lspm_chan_t c;
    c = lspm_chan_t'(idx ^ {1'b0, xover});
    return c;
  endfunction

  function automatic lspm_role_t pair_role(input lspm_speed_t spd, input logic xover,
                                           input logic [1:0] idx);
    lspm_role_t r;
    r = ROLE_UNUSED;
    if (spd == SPD_1000) begin
      r = ROLE_BIDIR;
    end else if (spd != SPD_RSVD && !idx[1]) begin
      r = (idx[0] ^ xover) ? ROLE_RX : ROLE_TX;
    end
    return r;
  endfunction

endpackage

// ---- shared/lspm_port_if.sv ----
`timescale 1ns/100ps
interface lspm_port_if;
  import lspm_pkg::*;
  logic link_up;
  lspm_speed_t speed;
  logic xover;
  logic rx_pkt;
  logic rx_dest_match;
  logic link_led_n;
  logic hundred_led_n;
  logic gigabit_led_n;
  logic activity_led_n;
  logic [PAIR_MAP_W-1:0] pair_chan;
  logic [PAIR_MAP_W-1:0] pair_role;
  modport dev(input link_up, speed, xover, rx_pkt, rx_dest_match,
              output link_led_n, hundred_led_n, gigabit_led_n, activity_led_n,
              pair_chan, pair_role);
  modport drv(output link_up, speed, xover, rx_pkt, rx_dest_match,
              input link_led_n, hundred_led_n, gigabit_led_n, activity_led_n,
              pair_chan, pair_role);
endinterface

// ---- design/lspm_port_ind.sv ----
`timescale 1ns/100ps
module lspm_port_ind #(
  parameter logic [lspm_pkg::FLASH_CNT_W-1:0] FLASH_CYC_P = lspm_pkg::FLASH_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  lspm_port_if.dev pif
);
  import lspm_pkg::*;

  logic [FLASH_CNT_W-1:0] flash_cnt_ff, nxt_flash_cnt;
  logic link_led_ff, nxt_link_led;
  logic hund_led_ff, nxt_hund_led;
  logic gig_led_ff, nxt_gig_led;
  logic flash_led_ff, nxt_flash_led;
  logic [PAIR_MAP_W-1:0] chan_ff, nxt_chan;
  logic [PAIR_MAP_W-1:0] role_ff, nxt_role;

  always_comb begin
    nxt_flash_cnt = flash_cnt_ff;
    // Retrigger keeps the LED lit through a burst of frames
    if (pif.rx_pkt && pif.rx_dest_match) begin
      nxt_flash_cnt = FLASH_CYC_P;
    end else if (flash_cnt_ff != '0) begin
      nxt_flash_cnt = flash_cnt_ff - FLASH_CNT_W'(1);
    end
    nxt_flash_led = (nxt_flash_cnt != '0) ? LED_ON : LED_OFF;
    nxt_link_led = pif.link_up ? LED_ON : LED_OFF;
    nxt_hund_led = (pif.link_up && pif.speed == SPD_100) ? LED_ON : LED_OFF;
    nxt_gig_led = (pif.link_up && pif.speed == SPD_1000) ? LED_ON : LED_OFF;
    for (int i = 0; i < PAIRS; i++) begin
      nxt_chan[2*i +: 2] = pair_chan(pif.xover, 2'(i));
      nxt_role[2*i +: 2] = pif.link_up ? pair_role(pif.speed, pif.xover, 2'(i))
                                       : ROLE_UNUSED;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flash_cnt_ff <= '0;
      link_led_ff <= LED_OFF;
      hund_led_ff <= LED_OFF;
      gig_led_ff <= LED_OFF;
      flash_led_ff <= LED_OFF;
      chan_ff <= PAIR_CHAN_STR;
      role_ff <= ROLE_MAP_IDLE;
    end else begin
      flash_cnt_ff <= nxt_flash_cnt;
      link_led_ff <= nxt_link_led;
      hund_led_ff <= nxt_hund_led;
      gig_led_ff <= nxt_gig_led;
      flash_led_ff <= nxt_flash_led;
      chan_ff <= nxt_chan;
      role_ff <= nxt_role;
    end
  end

  assign pif.link_led_n = link_led_ff;
  assign pif.hundred_led_n = hund_led_ff;
  assign pif.gigabit_led_n = gig_led_ff;
  assign pif.activity_led_n = flash_led_ff;
  assign pif.pair_chan = chan_ff;
  assign pif.pair_role = role_ff;

  default clocking cb @(posedge clk); endclocking

  sequence matched_rx;
    pif.rx_pkt && pif.rx_dest_match;
  endsequence
  sequence gig_link;
    pif.link_up && pif.speed == SPD_1000;
  endsequence

  flash_start_a: assert property (disable iff (!rst_n)
    matched_rx |=> pif.activity_led_n == LED_ON) else $error("no flash on own frame");
  flash_quiet_a: assert property (disable iff (!rst_n)
    pif.activity_led_n == LED_OFF && !(pif.rx_pkt && pif.rx_dest_match)
    |=> pif.activity_led_n == LED_OFF) else $error("flash without own frame");
  link_led_a: assert property (disable iff (!rst_n)
    1'b1 |=> pif.link_led_n == ($past(pif.link_up) ? LED_ON : LED_OFF))
    else $error("link LED does not follow link");
  hund_led_a: assert property (disable iff (!rst_n)
    !(pif.link_up && pif.speed == SPD_100) |=> pif.hundred_led_n == LED_OFF)
    else $error("100 LED lit off speed");
  gig_led_a: assert property (disable iff (!rst_n)
    gig_link |=> pif.gigabit_led_n == LED_ON && pif.hundred_led_n == LED_OFF)
    else $error("gigabit LED wrong");
  gig_map_a: assert property (disable iff (!rst_n)
    gig_link ##0 pif.xover |=> pif.pair_chan == PAIR_CHAN_XOVER && pif.pair_role == ROLE_MAP_GIG)
    else $error("crossover gigabit map wrong");
  slow_map_a: assert property (disable iff (!rst_n)
    pif.link_up && pif.speed inside {SPD_10, SPD_100}
    |=> pif.pair_role == ($past(pif.xover) ? ROLE_MAP_SLOW_XO : ROLE_MAP_SLOW_STR))
    else $error("slow pair roles wrong");
  reset_dark_a: assert property (
    !rst_n |=> pif.link_led_n && pif.activity_led_n && pif.gigabit_led_n && pif.hundred_led_n)
    else $error("LED lit after reset");

endmodule // lspm_port_ind

// ---- design/lspm_top.sv ----
`timescale 1ns/100ps
module lspm_top #(
  parameter logic [lspm_pkg::FLASH_CNT_W-1:0] FLASH_CYC_P = lspm_pkg::FLASH_CYC
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic PORT_A_LINK_UP,
  input wire lspm_pkg::lspm_speed_t PORT_A_SPEED,
  input wire logic PORT_A_CROSSOVER,
  input wire logic PORT_A_RX_PKT,
  input wire logic PORT_A_RX_DEST_MATCH,
  input wire logic PORT_B_LINK_UP,
  input wire lspm_pkg::lspm_speed_t PORT_B_SPEED,
  input wire logic PORT_B_CROSSOVER,
  input wire logic PORT_B_RX_PKT,
  input wire logic PORT_B_RX_DEST_MATCH,
  output logic PORT_A_LINK_LED_N,
  output logic PORT_A_SPEED_HUNDRED_LED_N,
  output logic PORT_A_SPEED_GIGABIT_LED_N,
  output logic PORT_A_ACTIVITY_LED_N,
  output logic [lspm_pkg::PAIR_MAP_W-1:0] PORT_A_LINE_PAIR_CHAN,
  output logic [lspm_pkg::PAIR_MAP_W-1:0] PORT_A_LINE_PAIR_ROLE,
  output logic PORT_B_LINK_LED_N,
  output logic PORT_B_SPEED_HUNDRED_LED_N,
  output logic PORT_B_SPEED_GIGABIT_LED_N,
  output logic PORT_B_ACTIVITY_LED_N,
  output logic [lspm_pkg::PAIR_MAP_W-1:0] PORT_B_LINE_PAIR_CHAN,
  output logic [lspm_pkg::PAIR_MAP_W-1:0] PORT_B_LINE_PAIR_ROLE,
  input wire logic EE_PIN_LOAD,
  input wire logic [lspm_pkg::PIN_W-1:0] EE_PIN_DIR,
  input wire logic [lspm_pkg::PIN_W-1:0] EE_PIN_OUT,
  input wire logic SW_PIN_WE,
  input wire logic [lspm_pkg::PIN_W-1:0] SW_PIN_DIR,
  input wire logic [lspm_pkg::PIN_W-1:0] SW_PIN_OUT,
  input wire logic [lspm_pkg::PIN_W-1:0] PIN_GPI_EN,
  input wire logic [lspm_pkg::PIN_W-1:0] SOFT_DEFINED_PIN_IN,
  output logic [lspm_pkg::PIN_W-1:0] SOFT_DEFINED_PIN_OUT,
  output logic [lspm_pkg::PIN_W-1:0] SOFT_DEFINED_PIN_OE,
  output logic [lspm_pkg::PIN_W-1:0] SOFT_DEFINED_PIN_LEVEL,
  output logic [lspm_pkg::PIN_W-1:0] SOFT_DEFINED_PIN_GPI
);
  import lspm_pkg::*;

  lspm_port_if port_a_if();
  lspm_port_if port_b_if();

  assign port_a_if.link_up = PORT_A_LINK_UP;
  assign port_a_if.speed = PORT_A_SPEED;
  assign port_a_if.xover = PORT_A_CROSSOVER;
  assign port_a_if.rx_pkt = PORT_A_RX_PKT;
  assign port_a_if.rx_dest_match = PORT_A_RX_DEST_MATCH;
  assign port_b_if.link_up = PORT_B_LINK_UP;
  assign port_b_if.speed = PORT_B_SPEED;
  assign port_b_if.xover = PORT_B_CROSSOVER;
  assign port_b_if.rx_pkt = PORT_B_RX_PKT;
  assign port_b_if.rx_dest_match = PORT_B_RX_DEST_MATCH;

  // Same logic serves both ports; activity filtering lives inside
  lspm_port_ind #(.FLASH_CYC_P(FLASH_CYC_P)) u_port_a (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .pif(port_a_if)
  );

  lspm_port_ind #(.FLASH_CYC_P(FLASH_CYC_P)) u_port_b (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .pif(port_b_if)
  );

  assign PORT_A_LINK_LED_N = port_a_if.link_led_n;
  assign PORT_A_SPEED_HUNDRED_LED_N = port_a_if.hundred_led_n;
  assign PORT_A_SPEED_GIGABIT_LED_N = port_a_if.gigabit_led_n;
  assign PORT_A_ACTIVITY_LED_N = port_a_if.activity_led_n;
  assign PORT_A_LINE_PAIR_CHAN = port_a_if.pair_chan;
  assign PORT_A_LINE_PAIR_ROLE = port_a_if.pair_role;
  assign PORT_B_LINK_LED_N = port_b_if.link_led_n;
  assign PORT_B_SPEED_HUNDRED_LED_N = port_b_if.hundred_led_n;
  assign PORT_B_SPEED_GIGABIT_LED_N = port_b_if.gigabit_led_n;
  assign PORT_B_ACTIVITY_LED_N = port_b_if.activity_led_n;
  assign PORT_B_LINE_PAIR_CHAN = port_b_if.pair_chan;
  assign PORT_B_LINE_PAIR_ROLE = port_b_if.pair_role;

  // General pin configuration: four slots only, so index five cannot be reached
  logic [PIN_W-1:0] dir_ff, nxt_dir;
  logic [PIN_W-1:0] out_ff, nxt_out;

  function automatic logic [PIN_W-1:0] pick_cfg(input logic sw_we, input logic ee_ld,
                                                 input logic [PIN_W-1:0] sw_val,
                                                 input logic [PIN_W-1:0] ee_val,
                                                 input logic [PIN_W-1:0] cur);
    logic [PIN_W-1:0] v;
    v = cur;
    // Software is the later authority, so it wins a same-cycle collision
    if (sw_we) begin
      v = sw_val;
    end else if (ee_ld) begin
      v = ee_val;
    end
    return v;
  endfunction

  always_comb begin
    nxt_dir = pick_cfg(SW_PIN_WE, EE_PIN_LOAD, SW_PIN_DIR, EE_PIN_DIR, dir_ff);
    nxt_out = pick_cfg(SW_PIN_WE, EE_PIN_LOAD, SW_PIN_OUT, EE_PIN_OUT, out_ff);
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      dir_ff <= PIN_DIR_RST;
      out_ff <= PIN_OUT_RST;
    end else begin
      dir_ff <= nxt_dir;
      out_ff <= nxt_out;
    end
  end

  assign SOFT_DEFINED_PIN_OE = dir_ff;
  assign SOFT_DEFINED_PIN_OUT = out_ff;

  // Pin input synchroniser; a level counts once stages two and three agree
  logic [PIN_W-1:0] pin_s1_ff, pin_s2_ff, pin_s3_ff;
  logic [PIN_W-1:0] lvl_ff, nxt_lvl;
  logic [PIN_W-1:0] gpi_ff, nxt_gpi;

  always_comb begin
    nxt_lvl = lvl_ff;
    for (int i = 0; i < PIN_W; i++) begin
      if (pin_s2_ff[i] == pin_s3_ff[i]) begin
        nxt_lvl[i] = pin_s3_ff[i];
      end
    end
    // Output pins never reach the interrupt bits; their echo is our own drive
    nxt_gpi = lvl_ff & ~dir_ff & PIN_GPI_EN;
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      pin_s1_ff <= PIN_LVL_RST;
      pin_s2_ff <= PIN_LVL_RST;
      pin_s3_ff <= PIN_LVL_RST;
      lvl_ff <= PIN_LVL_RST;
      gpi_ff <= PIN_LVL_RST;
    end else begin
      pin_s1_ff <= SOFT_DEFINED_PIN_IN;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
      lvl_ff <= nxt_lvl;
      gpi_ff <= nxt_gpi;
    end
  end

  assign SOFT_DEFINED_PIN_LEVEL = lvl_ff;
  assign SOFT_DEFINED_PIN_GPI = gpi_ff;

  default clocking cb @(posedge CLK_SYS); endclocking

  sequence pin_settled;
    $stable(SOFT_DEFINED_PIN_IN) [*5];
  endsequence
  sequence no_cfg;
    !SW_PIN_WE && !EE_PIN_LOAD;
  endsequence

  sw_dir_a: assert property (disable iff (!RST_N)
    SW_PIN_WE
    |=> SOFT_DEFINED_PIN_OE == $past(SW_PIN_DIR) && SOFT_DEFINED_PIN_OUT == $past(SW_PIN_OUT))
    else $error("direction write lost");
  dir_hold_a: assert property (disable iff (!RST_N)
    no_cfg |=> $stable(SOFT_DEFINED_PIN_OE)) else $error("direction moved unbidden");
  reset_input_a: assert property (
    !RST_N |=> SOFT_DEFINED_PIN_OE == PIN_DIR_RST) else $error("pin not input after reset");
  ee_load_a: assert property (disable iff (!RST_N)
    EE_PIN_LOAD && !SW_PIN_WE |=> SOFT_DEFINED_PIN_OE == $past(EE_PIN_DIR))
    else $error("EEPROM direction not applied");
  gpi_map_a: assert property (disable iff (!RST_N)
    1'b1 ##1 1'b1 |-> SOFT_DEFINED_PIN_GPI ==
      $past(SOFT_DEFINED_PIN_LEVEL & ~SOFT_DEFINED_PIN_OE & PIN_GPI_EN))
    else $error("interrupt routing wrong");
  pin_sync_a: assert property (disable iff (!RST_N)
    pin_settled |=> SOFT_DEFINED_PIN_LEVEL == $past(SOFT_DEFINED_PIN_IN))
    else $error("settled pin not seen");
  a_gig_led_a: assert property (disable iff (!RST_N)
    !PORT_A_LINK_UP |=> PORT_A_SPEED_GIGABIT_LED_N == LED_OFF && PORT_A_LINK_LED_N == LED_OFF)
    else $error("port A LEDs lit without link");
  b_map_a: assert property (disable iff (!RST_N)
    !PORT_B_CROSSOVER |=> PORT_B_LINE_PAIR_CHAN == PAIR_CHAN_STR)
    else $error("port B straight map wrong");

  // Pin-level view of both ports, so a swapped or miswired port instance shows up too
  sequence a_hund_up;
    PORT_A_LINK_UP && PORT_A_SPEED == SPD_100;
  endsequence
  sequence b_hund_up;
    PORT_B_LINK_UP && PORT_B_SPEED == SPD_100;
  endsequence

  b_gig_led_a: assert property (disable iff (!RST_N)
    !PORT_B_LINK_UP |=> PORT_B_SPEED_GIGABIT_LED_N == LED_OFF && PORT_B_LINK_LED_N == LED_OFF)
    else $error("port B LEDs lit without link");
  a_map_a: assert property (disable iff (!RST_N)
    !PORT_A_CROSSOVER |=> PORT_A_LINE_PAIR_CHAN == PAIR_CHAN_STR)
    else $error("port A straight map wrong");
  a_hund_on_a: assert property (disable iff (!RST_N)
    a_hund_up |=> PORT_A_SPEED_HUNDRED_LED_N == LED_ON && PORT_A_SPEED_GIGABIT_LED_N == LED_OFF)
    else $error("port A 100 LED dark at 100");
  b_hund_on_a: assert property (disable iff (!RST_N)
    b_hund_up |=> PORT_B_SPEED_HUNDRED_LED_N == LED_ON && PORT_B_SPEED_GIGABIT_LED_N == LED_OFF)
    else $error("port B 100 LED dark at 100");
  a_idle_roles_a: assert property (disable iff (!RST_N)
    !PORT_A_LINK_UP |=> PORT_A_LINE_PAIR_ROLE == ROLE_MAP_IDLE)
    else $error("port A pairs in use without link");
  b_idle_roles_a: assert property (disable iff (!RST_N)
    !PORT_B_LINK_UP |=> PORT_B_LINE_PAIR_ROLE == ROLE_MAP_IDLE)
    else $error("port B pairs in use without link");
  a_foreign_a: assert property (disable iff (!RST_N)
    PORT_A_RX_PKT && !PORT_A_RX_DEST_MATCH && PORT_A_ACTIVITY_LED_N == LED_OFF
    |=> PORT_A_ACTIVITY_LED_N == LED_OFF) else $error("port A flash on foreign frame");
  b_foreign_a: assert property (disable iff (!RST_N)
    PORT_B_RX_PKT && !PORT_B_RX_DEST_MATCH && PORT_B_ACTIVITY_LED_N == LED_OFF
    |=> PORT_B_ACTIVITY_LED_N == LED_OFF) else $error("port B flash on foreign frame");
  out_hold_a: assert property (disable iff (!RST_N)
    no_cfg |=> $stable(SOFT_DEFINED_PIN_OUT)) else $error("drive value moved unbidden");
  gpi_output_a: assert property (disable iff (!RST_N)
    1'b1 |=> (SOFT_DEFINED_PIN_GPI & $past(SOFT_DEFINED_PIN_OE)) == '0)
    else $error("output pin reached interrupt bit");

endmodule // lspm_top

// ---- verif/lspm_board_model.sv ----
`timescale 1ns/100ps
module lspm_board_model (
  input wire logic clk,
  input wire logic [3:0] pin_oe,
  input wire logic [3:0] pin_out,
  input wire logic [3:0] ext_en,
  input wire logic [3:0] ext_val,
  output logic [3:0] pin_in
);
  logic [3:0] float_ff = 4'h5;
  // No pull on these pins, so a released pin must not look like a held value
  always_ff @(posedge clk) begin
    float_ff <= ~float_ff;
  end
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (pin_oe[i]) begin
        pin_in[i] = pin_out[i];
      end else if (ext_en[i]) begin
        pin_in[i] = ext_val[i];
      end else begin
        pin_in[i] = float_ff[i];
      end
    end
  end
endmodule // lspm_board_model

// ---- verif/tb_led_sdp_pair_mapping.sv ----
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin n_fail++; \
  $display("unexpected %s: expected %h seen %h", nm, exp, got); end end
module tb_led_sdp_pair_mapping;
  import lspm_pkg::*;
  logic clk = 0, rst_n = 0, ee_ld = 0, sw_we = 0;
  logic [1:0] link = 0, xo = 0, pkt = 0, dm = 0;
  lspm_speed_t spd [2];
  logic [3:0] ee_dir = 0, ee_out = 0, sw_dir = 0, sw_out = 0;
  logic [3:0] gpi_en = 0, ext_en = 0, ext_val = 0;
  wire [3:0] pin_in, p_out, p_oe, p_lvl, p_gpi;
  wire [1:0] lk_n, h_n, g_n, act_n;
  wire [7:0] chan [2];
  wire [7:0] role [2];
  int n_fail = 0, comparisons = 0;

  always #50 clk = ~clk;

  lspm_top #(.FLASH_CYC_P(20'h8)) i_dut (
    .CLK_SYS(clk), .RST_N(rst_n),
    .PORT_A_LINK_UP(link[0]), .PORT_A_SPEED(spd[0]), .PORT_A_CROSSOVER(xo[0]),
    .PORT_A_RX_PKT(pkt[0]), .PORT_A_RX_DEST_MATCH(dm[0]),
    .PORT_B_LINK_UP(link[1]), .PORT_B_SPEED(spd[1]), .PORT_B_CROSSOVER(xo[1]),
    .PORT_B_RX_PKT(pkt[1]), .PORT_B_RX_DEST_MATCH(dm[1]),
    .PORT_A_LINK_LED_N(lk_n[0]), .PORT_A_SPEED_HUNDRED_LED_N(h_n[0]),
    .PORT_A_SPEED_GIGABIT_LED_N(g_n[0]), .PORT_A_ACTIVITY_LED_N(act_n[0]),
    .PORT_A_LINE_PAIR_CHAN(chan[0]), .PORT_A_LINE_PAIR_ROLE(role[0]),
    .PORT_B_LINK_LED_N(lk_n[1]), .PORT_B_SPEED_HUNDRED_LED_N(h_n[1]),
    .PORT_B_SPEED_GIGABIT_LED_N(g_n[1]), .PORT_B_ACTIVITY_LED_N(act_n[1]),
    .PORT_B_LINE_PAIR_CHAN(chan[1]), .PORT_B_LINE_PAIR_ROLE(role[1]),
    .EE_PIN_LOAD(ee_ld), .EE_PIN_DIR(ee_dir), .EE_PIN_OUT(ee_out),
    .SW_PIN_WE(sw_we), .SW_PIN_DIR(sw_dir), .SW_PIN_OUT(sw_out),
    .PIN_GPI_EN(gpi_en), .SOFT_DEFINED_PIN_IN(pin_in),
    .SOFT_DEFINED_PIN_OUT(p_out), .SOFT_DEFINED_PIN_OE(p_oe),
    .SOFT_DEFINED_PIN_LEVEL(p_lvl), .SOFT_DEFINED_PIN_GPI(p_gpi)
  );

  lspm_board_model i_board (
    .clk(clk), .pin_oe(p_oe), .pin_out(p_out), .ext_en(ext_en), .ext_val(ext_val),
    .pin_in(pin_in)
  );

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic scen_reset();
    `CHK("idle leds", 8'hff, {lk_n, h_n, g_n, act_n})
    `CHK("reset chan", 16'he4e4, {chan[0], chan[1]})
    `CHK("reset role", 16'h0000, {role[0], role[1]})
    `CHK("reset pin dir", 4'h0, p_oe)
  endtask

  task automatic check_port(input int p, input logic l, input lspm_speed_t s, input logic x);
    logic [7:0] er;
    link[p] = l;
    spd[p] = s;
    xo[p] = x;
    cyc(1);
    er = (!l || s == SPD_RSVD) ? 8'h00 : (s == SPD_1000) ? 8'hff : x ? 8'h06 : 8'h09;
    `CHK("link led", !l, lk_n[p])
    `CHK("hundred led", !(l && s == SPD_100), h_n[p])
    `CHK("gigabit led", !(l && s == SPD_1000), g_n[p])
    `CHK("pair chan", x ? 8'hb1 : 8'he4, chan[p])
    `CHK("pair role", er, role[p])
  endtask

  task automatic scen_link();
    for (int p = 0; p < 2; p++)
      for (int l = 0; l < 2; l++)
        for (int s = 0; s < 4; s++)
          for (int x = 0; x < 2; x++)
            check_port(p, l[0], lspm_speed_t'(s), x[0]);
    link = 0;
    xo = 0;
  endtask

  task automatic scen_activity(input int p);
    pkt[p] = 1;
    cyc(1);
    pkt[p] = 0;
    `CHK("foreign frame", 2'b11, act_n)
    pkt[p] = 1;
    dm[p] = 1;
    cyc(1);
    pkt[p] = 0;
    dm[p] = 0;
    `CHK("matched frame", 1'b0, act_n[p])
    `CHK("other port quiet", 1'b1, act_n[1-p])
    cyc(7);
    `CHK("flash held", 1'b0, act_n[p])
    cyc(1);
    `CHK("flash ended", 1'b1, act_n[p])
  endtask

  task automatic scen_pins();
    ee_ld = 1;
    ee_dir = 4'h3;
    ee_out = 4'h1;
    cyc(1);
    ee_ld = 0;
    `CHK("eeprom dir", 4'h3, p_oe)
    `CHK("eeprom out", 4'h1, p_out)
    sw_we = 1;
    sw_dir = 4'hc;
    sw_out = 4'h4;
    cyc(1);
    `CHK("sw dir", 4'hc, p_oe)
    `CHK("sw out", 4'h4, p_out)
    ee_ld = 1;
    ee_dir = 4'ha;
    ee_out = 4'hf;
    sw_dir = 4'h5;
    sw_out = 4'h0;
    cyc(1);
    ee_ld = 0;
    `CHK("both strobes", 4'h5, p_oe)
    sw_dir = 4'h0;
    cyc(1);
    sw_we = 0;
    ext_en = 4'hf;
    ext_val = 4'h8;
    gpi_en = 4'h8;
    cyc(6);
    `CHK("pin level", 4'h8, p_lvl)
    `CHK("gpi routed", 4'h8, p_gpi)
    gpi_en = 4'h0;
    cyc(2);
    `CHK("gpi masked", 4'h0, p_gpi)
    gpi_en = 4'hf;
    sw_we = 1;
    sw_dir = 4'h8;
    sw_out = 4'h8;
    cyc(1);
    sw_we = 0;
    cyc(6);
    `CHK("driven level", 4'h8, p_lvl)
    `CHK("gpi on output", 4'h0, p_gpi)
    `CHK("group width", 4, $bits(p_oe))
  endtask

  task automatic scen_midreset();
    link[0] = 1;
    spd[0] = SPD_1000;
    pkt[0] = 1;
    dm[0] = 1;
    cyc(1);
    pkt[0] = 0;
    dm[0] = 0;
    rst_n = 0;
    cyc(1);
    `CHK("leds in reset", 3'b111, {lk_n[0], g_n[0], act_n[0]})
    rst_n = 1;
    cyc(2);
    `CHK("link after reset", 2'b00, {lk_n[0], g_n[0]})
    `CHK("flash cleared", 1'b1, act_n[0])
  endtask

  initial begin
    spd[0] = SPD_10;
    spd[1] = SPD_10;
    cyc(19);
    scen_reset();
    cyc(1);
    rst_n = 1;
    cyc(1);
    scen_link();
    scen_activity(0);
    scen_activity(1);
    scen_pins();
    scen_midreset();
    complete_run();
  end

  // About 100 cycles expected; twenty times that means a hang
  initial begin
    #(100 * 2000);
    n_fail++;
    $display("unexpected watchdog: expected finish seen timeout");
    complete_run();
  end
endmodule // tb_led_sdp_pair_mapping
